// file: hw/uic_pkg.sv
// Constants and field layout of the ULPI interface control register block
// How it works
// - Register reads 07h-09h; write, set, clear
// - Protect on: STP pull-up, float pulls data
// - Device detects link releasing STP itself
// - Protect disable removes all weak pulls
// - Fault forwarded without bus-voltage qualification
// - Fault-invert bit inverts overcurrent input
// - Serial-clock bit keeps clock in serial
// - Serial-clock bit only serial and powered
// - Serial-clock bit affects clock only
// - Three-wire bit selects three-wire serial
// - Device clears three-wire bit on exit
// - Six-wire bit selects, cleared on exit
// - STP wakes low power; bit returns one
package uic_pkg;
   // Register port geometry
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   // Register addresses: read range, write, set, clear
   localparam logic [5:0] ADDR_WRITE = 6'h07;
   localparam logic [5:0] ADDR_SET   = 6'h08;
   localparam logic [5:0] ADDR_CLEAR = 6'h09;
   // Reset value and writable bits; bits 4 and 2 reserved, read zero
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_MASK  = 8'hEB;
   // Field positions
   localparam int BIT_PROT_DIS   = 7;
   localparam int BIT_PASSTHRU   = 6;
   localparam int BIT_FAULT_INV  = 5;
   localparam int BIT_CLK_KEEP   = 3;
   localparam int BIT_THREE_WIRE = 1;
   localparam int BIT_SIX_WIRE   = 0;
   // Bits the device clears itself when serial mode ends
   localparam logic [7:0] SERIAL_BITS = 8'h03;
   // Cycles STP must read high with the bus idle before it counts as floated
   localparam logic [1:0] STP_FLOAT_CYC = 2'h2;
   // Low-power-not value out of reset: powered
   localparam logic LPN_RESET = 1'b1;
endpackage

// file: hw/uic_regfile.sv
// Interface control register storage with write, set and clear decoding
`timescale 1ns/1ps
module uic_regfile (
   input  wire logic                      mclk_in,
   input  wire logic                      resetn_in,
   input  wire logic [uic_pkg::ADDR_W-1:0] reg_addr_in,
   input  wire logic                      reg_wr_in,
   input  wire logic                      reg_rd_in,
   input  wire logic [uic_pkg::DATA_W-1:0] reg_wdata_in,
   input  wire logic                      serial_exit_in,
   output logic      [uic_pkg::DATA_W-1:0] ctrl_out,
   output logic      [uic_pkg::DATA_W-1:0] rdata_out,
   output logic                           rvalid_out
);
   import uic_pkg::*;

   logic [7:0] ctrl_reg;   // Stored control bits
   logic [7:0] ctrl_next;  // Value for the next edge
   logic       hit;        // Address falls in 07h..09h

   assign hit = (reg_addr_in >= ADDR_WRITE) && (reg_addr_in <= ADDR_CLEAR);

   ////////////////////////////////////////////////////////////////////////
   // Next value: hardware exit clear first, then a link write on top.
   // A link write in the exit cycle wins, since it is the newer request.
   always_comb begin
      ctrl_next = ctrl_reg;
      if (serial_exit_in) begin
         ctrl_next = ctrl_next & ~SERIAL_BITS;
      end
      if (reg_wr_in) begin
         case (reg_addr_in)
            ADDR_WRITE: ctrl_next = reg_wdata_in & CTRL_MASK;
            ADDR_SET:   ctrl_next = ctrl_next | (reg_wdata_in & CTRL_MASK);
            ADDR_CLEAR: ctrl_next = ctrl_next & ~reg_wdata_in;
            default:    ctrl_next = ctrl_next;
         endcase
      end
   end

   // Register update
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         ctrl_reg <= CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port: all three addresses return the register, others zero
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         rdata_out  <= 8'h00;
         rvalid_out <= 1'b0;
      end else begin
         rdata_out  <= (reg_rd_in && hit) ? ctrl_reg : 8'h00;
         rvalid_out <= reg_rd_in && hit;
      end
   end

   assign ctrl_out = ctrl_reg;
endmodule

// file: hw/uic_top.sv
// ULPI interface control: register, pin protection, fault path, clock gate
`timescale 1ns/1ps
module uic_top (
   input  wire logic                      mclk_in,
   input  wire logic                      resetn_in,
   input  wire logic [uic_pkg::ADDR_W-1:0] reg_addr_in,
   input  wire logic                      reg_wr_in,
   input  wire logic                      reg_rd_in,
   input  wire logic [uic_pkg::DATA_W-1:0] reg_wdata_in,
   output logic      [uic_pkg::DATA_W-1:0] reg_rdata_out,
   output logic                           reg_rvalid_out,
   input  wire logic                      stp_in,
   input  wire logic                      dir_in,
   input  wire logic                      fault_pin_in,
   input  wire logic                      serial_exit_in,
   input  wire logic                      low_power_enter_in,
   output logic                           stp_pullup_en_out,
   output logic                           data_pulldown_en_out,
   output logic                           fault_ind_out,
   output logic                           three_wire_mode_out,
   output logic                           six_wire_mode_out,
   output logic                           clock_power_out,
   output logic                           low_power_not_out
);
   import uic_pkg::*;

   logic [7:0] ctrl;            // Current register contents
   logic [1:0] float_cnt_reg;   // Cycles STP has read high while idle
   logic [1:0] float_cnt_next;  // Next float count
   logic       stp_float;       // Link has let STP go
   logic       low_power_not_reg;  // Powered when one
   logic       serial_on;       // Either serial mode selected
   logic       prot_on;         // Protection circuit enabled

   ////////////////////////////////////////////////////////////////////////
   // Register storage and read port
   uic_regfile u_regfile (
      .mclk_in        (mclk_in),
      .resetn_in      (resetn_in),
      .reg_addr_in    (reg_addr_in),
      .reg_wr_in      (reg_wr_in),
      .reg_rd_in      (reg_rd_in),
      .reg_wdata_in   (reg_wdata_in),
      .serial_exit_in (serial_exit_in),
      .ctrl_out       (ctrl),
      .rdata_out      (reg_rdata_out),
      .rvalid_out     (reg_rvalid_out)
   );

   assign prot_on   = !ctrl[BIT_PROT_DIS];
   assign serial_on = ctrl[BIT_THREE_WIRE] || ctrl[BIT_SIX_WIRE];

   ////////////////////////////////////////////////////////////////////////
   // STP float detection. With the pull-up on, a released STP reads high.
   // High while the device does not own the bus is unexpected, but one
   // cycle of it is a normal stop strobe, so it must persist a little.
   always_comb begin
      float_cnt_next = float_cnt_reg;
      if (!prot_on || !stp_in || dir_in) begin
         // Driven low, bus turned round, or protection off: restart
         float_cnt_next = 2'h0;
      end else if (float_cnt_reg != STP_FLOAT_CYC) begin
         float_cnt_next = float_cnt_reg + 2'h1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         float_cnt_reg <= 2'h0;
      end else begin
         float_cnt_reg <= float_cnt_next;
      end
   end

   assign stp_float = (float_cnt_next == STP_FLOAT_CYC);

   ////////////////////////////////////////////////////////////////////////
   // Weak pull controls for the ULPI pins
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         stp_pullup_en_out    <= 1'b0;
         data_pulldown_en_out <= 1'b0;
      end else begin
         stp_pullup_en_out    <= prot_on;
         data_pulldown_en_out <= prot_on && stp_float;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Overcurrent path. The pass-through bit is stored only; no comparator
   // qualification exists, so the bit has no other effect on this path.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         fault_ind_out <= 1'b0;
      end else begin
         fault_ind_out <= fault_pin_in ^ ctrl[BIT_FAULT_INV];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Low-power state. STP from the link wakes the device; the wake wins
   // over an enter request in the same cycle so a wake is never lost.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         low_power_not_reg <= LPN_RESET;
      end else if (!low_power_not_reg && stp_in) begin
         low_power_not_reg <= 1'b1;
      end else if (low_power_enter_in) begin
         low_power_not_reg <= 1'b0;
      end
   end

   assign low_power_not_out = low_power_not_reg;

   ////////////////////////////////////////////////////////////////////////
   // Clock power. Only this output looks at the keep-on bit, so a cleared
   // bit in serial mode, while powered, stops the clock alone and leaves every other path running.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         clock_power_out <= 1'b0;
      end else if (serial_on && low_power_not_reg) begin
         clock_power_out <= ctrl[BIT_CLK_KEEP];
      end else begin
         clock_power_out <= low_power_not_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interface mode selects; neither set means the parallel interface.
   // Both set is the link's fault and is passed through as it stands.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         three_wire_mode_out <= 1'b0;
         six_wire_mode_out   <= 1'b0;
      end else begin
         three_wire_mode_out <= ctrl[BIT_THREE_WIRE];
         six_wire_mode_out   <= ctrl[BIT_SIX_WIRE];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks on the behaviour above. Checks that start on every edge take
   // the sampled reset into the antecedent: at the release edge the flops
   // still saw reset, so that edge must not start an attempt.
   a_read_returns_reg:
   assert property (@(posedge mclk_in) disable iff (!resetn_in)
      reg_rd_in && reg_addr_in >= ADDR_WRITE && reg_addr_in <= ADDR_CLEAR
      |=> reg_rvalid_out && reg_rdata_out == $past(ctrl))
      else $error("read at 07h-09h did not return register");

   a_plain_write_loads:
   assert property (@(posedge mclk_in) disable iff (!resetn_in)
      reg_wr_in && reg_addr_in == ADDR_WRITE
      |=> ctrl == ($past(reg_wdata_in) & CTRL_MASK))
      else $error("plain write not stored");

   a_set_only_ones:
   assert property (@(posedge mclk_in) disable iff (!resetn_in)
      reg_wr_in && reg_addr_in == ADDR_SET && !serial_exit_in
      |=> ctrl == ($past(ctrl) | ($past(reg_wdata_in) & CTRL_MASK)))
      else $error("set write changed wrong bits");

   a_clear_only_ones:
   assert property (@(posedge mclk_in) disable iff (!resetn_in)
      reg_wr_in && reg_addr_in == ADDR_CLEAR && !serial_exit_in
      |=> ctrl == ($past(ctrl) & ~$past(reg_wdata_in)))
      else $error("clear write changed wrong bits");

   a_pullup_follows_bit:
   assert property (@(posedge mclk_in) disable iff (!resetn_in)
      $rose(ctrl[BIT_PROT_DIS]) |=> !stp_pullup_en_out)
      else $error("pull-up still on after protect disable");

   a_float_pulls_data:
   assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (prot_on && stp_in && !dir_in)[*2] |=> data_pulldown_en_out)
      else $error("floated STP did not attach data pull-downs");

   a_disable_drops_pulls:
   assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ctrl[BIT_PROT_DIS] |=> !data_pulldown_en_out && !stp_pullup_en_out)
      else $error("weak pulls present with protection disabled");

   a_fault_inversion:
   assert property (@(posedge mclk_in) disable iff (!resetn_in)
      resetn_in |=> fault_ind_out
                    == ($past(fault_pin_in) ^ $past(ctrl[BIT_FAULT_INV])))
      else $error("fault indicator polarity wrong");

   a_clock_keep_serial:
   assert property (@(posedge mclk_in) disable iff (!resetn_in)
      serial_on && low_power_not_reg
      |=> clock_power_out == $past(ctrl[BIT_CLK_KEEP]))
      else $error("clock power ignores keep-on bit in serial mode");

   a_clock_bit_ignored:
   assert property (@(posedge mclk_in) disable iff (!resetn_in)
      resetn_in && !serial_on
      |=> clock_power_out == $past(low_power_not_reg))
      else $error("keep-on bit acted outside serial mode");

   a_exit_clears_serial:
   assert property (@(posedge mclk_in) disable iff (!resetn_in)
      serial_exit_in && !reg_wr_in
      |-> ##2 !three_wire_mode_out && !six_wire_mode_out)
      else $error("serial select survived mode exit");

   a_stp_wakes_device:
   assert property (@(posedge mclk_in) disable iff (!resetn_in)
      !low_power_not_reg && stp_in |=> low_power_not_out)
      else $error("STP did not leave low-power mode");

   a_mode_outputs_track:
   assert property (@(posedge mclk_in) disable iff (!resetn_in)
      resetn_in |=> three_wire_mode_out == $past(ctrl[BIT_THREE_WIRE])
                    && six_wire_mode_out == $past(ctrl[BIT_SIX_WIRE]))
      else $error("serial mode outputs do not follow select bits");
endmodule

// file: test/uic_link_model.sv
// Link-side model of the STP pin with the device's weak pull-up
`timescale 1ns/1ps
module uic_link_model (
   input  wire logic mclk_in,
   input  wire logic pullup_en_in,
   input  wire logic release_in,
   input  wire logic drive_in,
   output logic      stp_out
);
   logic wander_reg = 1'h0; // Level of an undriven, unpulled pin
   // A floating pin changes every cycle so no level is ever assumed
   always_ff @(posedge mclk_in) begin
      wander_reg <= ~wander_reg;
   end
   // Link drives, else the device pull-up holds it high, else it wanders
   assign stp_out = !release_in ? drive_in :
                    pullup_en_in ? 1'h1 : wander_reg;
endmodule

// file: test/testbench.sv
// Self-checking bench for the interface control block
`timescale 1ns/1ps
module testbench;
   import uic_pkg::*;
   logic       mclk = 1'h0;   // Bench clock
   logic       resetn = 1'h0; // Reset, active low
   logic [5:0] addr = 6'h00;  // Register port request
   logic       wr = 1'h0;
   logic       rd = 1'h0;
   logic [7:0] wdata = 8'h00;
   logic       fault = 1'h0;  // Overcurrent pin level
   logic       sexit = 1'h0;  // Core strobes
   logic       lpe = 1'h0;
   logic       rel = 1'h0;    // Link lets go of STP
   logic       drv = 1'h0;    // Level the link drives on STP
   logic       dir = 1'h0;    // Bus direction, device owns it when high
   logic       stp;
   logic [7:0] rdata;
   logic       rvalid, pu, pd, fi, m3, m6, clkp, lpn;
   logic [7:0] q[$];          // Expected read data, oldest first
   logic [7:0] seed = 8'h10;
   logic [7:0] ctrl, v;       // Expected register, random value
   int         err_total = 0;
   int         n_compared = 0;
   int         cyc = 0;

   always #4 mclk = ~mclk;

   uic_top dut (.mclk_in(mclk), .resetn_in(resetn), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .stp_in(stp),
      .dir_in(dir), .fault_pin_in(fault), .serial_exit_in(sexit),
      .low_power_enter_in(lpe), .stp_pullup_en_out(pu),
      .data_pulldown_en_out(pd), .fault_ind_out(fi),
      .three_wire_mode_out(m3), .six_wire_mode_out(m6),
      .clock_power_out(clkp), .low_power_not_out(lpn));
   uic_link_model link (.mclk_in(mclk), .pullup_en_in(pu),
      .release_in(rel), .drive_in(drv), .stp_out(stp));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      chk(8'(q.size()), 8'h00);
      if (err_total == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // One register request held for exactly one taken edge
   task automatic bus(input logic [5:0] a, input logic [7:0] d,
                      input logic w);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge mclk);
      wr <= 1'h0;
      rd <= 1'h0;
   endtask
   task automatic rdchk(input logic [5:0] a);
      q.push_back(ctrl);
      bus(a, 8'h00, 1'h0);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   // One-cycle strobe: 0 low-power enter, 1 serial exit, 2 STP high
   task automatic strobe(input int k);
      @(posedge mclk);
      case (k)
         0: lpe <= 1'h1;
         1: sexit <= 1'h1;
         default: drv <= 1'h1;
      endcase
      @(posedge mclk);
      lpe <= 1'h0;
      sexit <= 1'h0;
      drv <= 1'h0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Every read answer is matched against the oldest note
   always @(posedge mclk) begin
      if (rvalid === 1'h1) begin
         if (q.size() == 0) begin
            err_total++;
            $display("[ERR] %0t seen=%h exp=%h", $time, rdata, 8'h00);
         end else begin
            chk(rdata, q.pop_front());
         end
      end
   end
   // Cuts a hang short
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         finish_test();
      end
   end

   initial begin
      repeat (4) @(posedge mclk);
      resetn <= 1'h1;
      wait_n(2);
      chk(pu, 8'h01);
      chk(pd, 8'h00);
      chk(lpn, 8'h01);
      chk(clkp, 8'h01);
      ctrl = CTRL_RESET;
      for (int a = 7; a <= 9; a++) rdchk(6'(a));
      // Random write, set, clear over bits 7-2, serial select bits 1 and 0 kept zero
      // pass-through kept one
      for (int i = 0; i < 9; i++) begin
         seed = lfsr(seed);
         v = (seed | 8'h40) & 8'hFC;
         case (i % 3)
            0: ctrl = v & CTRL_MASK;
            1: ctrl = ctrl | (v & CTRL_MASK);
            default: ctrl = ctrl & ~(v & 8'hBF);
         endcase
         bus(6'(7 + i % 3), (i % 3 == 2) ? (v & 8'hBF) : v, 1'h1);
         bus(6'h0A, 8'hFF, 1'h1);
         rdchk(6'(7 + i % 3));
         bus(6'h06, 8'h00, 1'h0);
      end
      // Fault path, plain then inverted
      for (int inv = 0; inv < 2; inv++) begin
         bus(ADDR_WRITE, inv ? 8'h60 : 8'h40, 1'h1);
         for (int j = 0; j < 4; j++) begin
            seed = lfsr(seed);
            @(posedge mclk);
            fault <= seed[0];
            wait_n(1);
            chk(fi, 8'(seed[0] ^ inv[0]));
         end
      end
      // Three-wire mode, clock keep, low power and wake
      bus(ADDR_WRITE, 8'h42, 1'h1);
      wait_n(2);
      chk(m3, 8'h01);
      chk(clkp, 8'h00);
      bus(ADDR_SET, 8'h08, 1'h1);
      wait_n(2);
      chk(clkp, 8'h01);
      chk(lpn, 8'h01);
      strobe(0);
      wait_n(2);
      chk(lpn, 8'h00);
      chk(clkp, 8'h00);
      strobe(2);
      wait_n(2);
      chk(lpn, 8'h01);
      chk(pd, 8'h00);
      strobe(1);
      wait_n(2);
      chk(m3, 8'h00);
      ctrl = 8'h48;
      rdchk(ADDR_WRITE);
      // Six-wire mode
      bus(ADDR_SET, 8'h01, 1'h1);
      bus(ADDR_CLEAR, 8'h08, 1'h1);
      wait_n(2);
      chk(m6, 8'h01);
      chk(clkp, 8'h00);
      strobe(1);
      wait_n(2);
      chk(m6, 8'h00);
      ctrl = 8'h40;
      rdchk(ADDR_CLEAR);
      // Link lets STP float, then protection is switched off and on
      @(posedge mclk);
      rel <= 1'h1;
      wait_n(4);
      chk(pd, 8'h01);
      // Device turns the bus round: a high STP is then expected
      @(posedge mclk);
      dir <= 1'h1;
      wait_n(2);
      chk(pd, 8'h00);
      @(posedge mclk);
      dir <= 1'h0;
      wait_n(3);
      chk(pd, 8'h01);
      bus(ADDR_SET, 8'h80, 1'h1);
      wait_n(2);
      chk(pu, 8'h00);
      chk(pd, 8'h00);
      bus(ADDR_CLEAR, 8'h80, 1'h1);
      wait_n(2);
      chk(pu, 8'h01);
      @(posedge mclk);
      rel <= 1'h0;
      wait_n(3);
      chk(pd, 8'h00);
      finish_test();
   end
endmodule
